// >>> shared/dmd_pkg.sv
// Package for the data memory map decoder: map constants, kinds and carriers
package dmd_pkg;

   // ----------------------------------------------------------------
   // Memory sizes and address bounds
   // ----------------------------------------------------------------
   localparam int          TOTAL_RAM_BYTES = 1024;
   localparam int          IRAM_BYTES      = 256;
   localparam int          EXP_RAM_BYTES   = 768;
   localparam logic [7:0]  LOW_RAM_TOP     = 8'h7f;
   localparam logic [15:0] EXP_RAM_TOP     = 16'h02ff;
   localparam logic [15:0] EXP_RAM_REG_TOP = 16'h00ff;

   // ----------------------------------------------------------------
   // Locally held special function registers
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_PTR_LOW    = 8'h82;
   localparam logic [7:0]  ADDR_PTR_HIGH   = 8'h83;
   localparam logic [7:0]  ADDR_AUX        = 8'h8e;
   localparam logic [7:0]  ADDR_AUX_ONE    = 8'ha2;
   localparam int          EXT_SEL_BIT     = 1;
   localparam int          PTR_SEL_BIT     = 0;
   localparam logic        EXT_SEL_RST     = 1'b0;
   localparam logic        PTR_SEL_RST     = 1'b0;
   localparam logic [15:0] PTR_RST         = 16'h0000;

   // ----------------------------------------------------------------
   // External strobe timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          STROBE_NS       = 400;
   localparam int          STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  STROBE_LAST     = 3'(STROBE_CYC - 1);

   // ----------------------------------------------------------------
   // Access kinds
   // ----------------------------------------------------------------
   localparam logic [2:0]  KIND_DIRECT     = 3'h0;
   localparam logic [2:0]  KIND_INDIRECT   = 3'h1;
   localparam logic [2:0]  KIND_STACK      = 3'h2;
   localparam logic [2:0]  KIND_EXT_REG    = 3'h3;
   localparam logic [2:0]  KIND_EXT_PTR    = 3'h4;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        inc;
      logic [2:0]  kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } dmd_cpu_req_t;

   typedef struct packed {
      logic       done;
      logic [7:0] rdata;
   } dmd_cpu_rsp_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmd_sfr_req_t;

   typedef struct packed {
      logic [7:0] port_zero_out;
      logic       port_zero_oe;
      logic [7:0] port_two_out;
      logic       ale;
      logic       wr_n;
      logic       rd_n;
   } dmd_ext_bus_t;

endpackage : dmd_pkg

// >>> hdl/dmd_decoder.sv
// Data memory map decoder: internal RAM, expanded RAM, SPECIAL_FUNCTION_REGISTER steering, external bus
// What this block does
// - One kilobyte on-chip RAM: 256 internal plus expanded
// - Addresses 00-7F hit low RAM, both modes
// - Indirect 80-FF hits upper RAM bank only
// - Direct 80-FF hits SPECIAL_FUNCTION_REGISTER space, separate storage
// - Above 7F: indirect picks RAM, direct SPECIAL_FUNCTION_REGISTER
// - Select clear: external moves 000-2FF hit expanded RAM
// - Expanded RAM hits leave ports and strobes alone
// - Select clear: pointer moves 0300-FFFF go external
// - Select clear: register moves reach expanded 00-FF
// - Select set: every external move uses strobes
// - Register moves put 8-bit address on port zero
// - Pointer moves: high on port two, low muxed
// - Write strobe bit six, read strobe bit seven
// - Stack uses only 256-byte internal RAM
// - Two 16-bit pointers chosen by select bit
// - Increment of aux register one toggles pointer
`timescale 1ns/1ps
`default_nettype none

module dmd_decoder
   import dmd_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire dmd_cpu_req_t cpu_req,
   output var  logic         cpu_ready,
   output var  dmd_cpu_rsp_t cpu_rsp,
   output var  dmd_sfr_req_t sfr_req,
   input  wire logic [7:0]   sfr_rdata,
   output var  dmd_ext_bus_t ext_bus,
   input  wire logic [7:0]   port_zero_in
);

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_SFR    = 5'b00010,
      ST_ADDR   = 5'b00100,
      ST_STROBE = 5'b01000,
      ST_HOLD   = 5'b10000
   } dmd_state_t;

   logic [7:0]  iram_r [IRAM_BYTES];
   logic [7:0]  exp_ram_r [EXP_RAM_BYTES];
   logic [15:0] data_pointer_first_r;
   logic [15:0] data_pointer_second_r;
   logic        ext_mem_select_r;
   logic        pointer_select_r;
   dmd_state_t  state_r;
   logic [2:0]  strobe_cnt_r;
   logic        ext_write_r;
   logic [7:0]  ext_wdata_r;
   logic [7:0]  port_zero_meta_r;
   logic [7:0]  port_zero_sync_r;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        take;
   logic        is_direct;
   logic        is_ext_move;
   logic        hit_iram;
   logic        hit_sfr;
   logic        hit_local;
   logic        hit_exp_ram;
   logic        hit_ext;
   logic [15:0] data_pointer;
   logic [15:0] eff_addr;
   logic [7:0]  local_rdata;

   assign take      = ce && cpu_req.valid && (state_r == ST_IDLE);
   assign is_direct = (cpu_req.kind == KIND_DIRECT);
   assign is_ext_move = (cpu_req.kind == KIND_EXT_REG) || (cpu_req.kind == KIND_EXT_PTR);
   // Selected pointer drives both pointer moves and pointer byte access
   assign data_pointer = pointer_select_r ? data_pointer_second_r
                                          : data_pointer_first_r;
   assign eff_addr  = (cpu_req.kind == KIND_EXT_PTR) ? data_pointer
                                                      : {8'h00, cpu_req.addr[7:0]};
   // Stack and indirect use the full 8-bit index into internal RAM only
   assign hit_iram  = (cpu_req.kind == KIND_INDIRECT) || (cpu_req.kind == KIND_STACK)
                      || (is_direct && cpu_req.addr[7:0] <= LOW_RAM_TOP);
   assign hit_sfr   = is_direct && (cpu_req.addr[7:0] > LOW_RAM_TOP);
   assign hit_local = hit_sfr && ((cpu_req.addr[7:0] == ADDR_PTR_LOW)
                      || (cpu_req.addr[7:0] == ADDR_PTR_HIGH)
                      || (cpu_req.addr[7:0] == ADDR_AUX)
                      || (cpu_req.addr[7:0] == ADDR_AUX_ONE));
   // Register moves carry only 8 address bits, so they never see 100-2FF
   assign hit_exp_ram = !ext_mem_select_r
                      && ((cpu_req.kind == KIND_EXT_REG)
                      || (cpu_req.kind == KIND_EXT_PTR && eff_addr <= EXP_RAM_TOP));
   assign hit_ext   = is_ext_move && !hit_exp_ram;

   always_comb begin
      local_rdata = 8'h00;
      case (cpu_req.addr[7:0])
         ADDR_PTR_LOW:  local_rdata = data_pointer[7:0];
         ADDR_PTR_HIGH: local_rdata = data_pointer[15:8];
         ADDR_AUX:      local_rdata[EXT_SEL_BIT] = ext_mem_select_r;
         ADDR_AUX_ONE:  local_rdata[PTR_SEL_BIT] = pointer_select_r;
         default:       local_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         port_zero_meta_r <= 8'h00;
         port_zero_sync_r <= 8'h00;
      end else if (ce) begin
         port_zero_meta_r <= port_zero_in;
         port_zero_sync_r <= port_zero_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Control bits and data pointers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_mem_select_r      <= EXT_SEL_RST;
         pointer_select_r      <= PTR_SEL_RST;
         data_pointer_first_r  <= PTR_RST;
         data_pointer_second_r <= PTR_RST;
      end else if (take && hit_local && (cpu_req.write || cpu_req.inc)) begin
         case (cpu_req.addr[7:0])
            ADDR_AUX: begin
               if (cpu_req.write) begin
                  ext_mem_select_r <= cpu_req.wdata[EXT_SEL_BIT];
               end
            end
            ADDR_AUX_ONE: begin
               // Increment flips only the select bit; upper bits hold nothing here
               if (cpu_req.inc) begin
                  pointer_select_r <= !pointer_select_r;
               end else begin
                  pointer_select_r <= cpu_req.wdata[PTR_SEL_BIT];
               end
            end
            ADDR_PTR_LOW: begin
               if (pointer_select_r) begin
                  data_pointer_second_r[7:0] <= cpu_req.inc ? data_pointer[7:0] + 8'h01
                                                            : cpu_req.wdata;
               end else begin
                  data_pointer_first_r[7:0] <= cpu_req.inc ? data_pointer[7:0] + 8'h01
                                                           : cpu_req.wdata;
               end
            end
            ADDR_PTR_HIGH: begin
               if (pointer_select_r) begin
                  data_pointer_second_r[15:8] <= cpu_req.inc ? data_pointer[15:8] + 8'h01
                                                             : cpu_req.wdata;
               end else begin
                  data_pointer_first_r[15:8] <= cpu_req.inc ? data_pointer[15:8] + 8'h01
                                                            : cpu_req.wdata;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // On-chip RAM writes
   // ----------------------------------------------------------------
   // No reset on the arrays: contents are undefined after power-up
   always_ff @(posedge clk) begin
      if (!rst && take && cpu_req.write) begin
         if (hit_iram) begin
            iram_r[cpu_req.addr[7:0]] <= cpu_req.wdata;
         end
         if (hit_exp_ram) begin
            exp_ram_r[eff_addr[9:0]] <= cpu_req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and external bus
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r      <= ST_IDLE;
         cpu_ready    <= 1'b1;
         strobe_cnt_r <= 3'h0;
         ext_write_r  <= 1'b0;
         ext_wdata_r  <= 8'h00;
         sfr_req      <= '0;
         ext_bus      <= '{port_zero_out: 8'h00, port_zero_oe: 1'b0, port_two_out: 8'h00,
                           ale: 1'b0, wr_n: 1'b1, rd_n: 1'b1};
      end else if (ce) begin
         sfr_req.valid <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (take && hit_sfr && !hit_local) begin
                  // Other SFRs live elsewhere; forward and wait one cycle
                  sfr_req   <= '{valid: 1'b1, write: cpu_req.write,
                                 addr: cpu_req.addr[7:0], wdata: cpu_req.wdata};
                  state_r   <= ST_SFR;
                  cpu_ready <= 1'b0;
               end else if (take && hit_ext) begin
                  ext_write_r    <= cpu_req.write;
                  ext_wdata_r    <= cpu_req.wdata;
                  ext_bus.ale    <= 1'b1;
                  ext_bus.port_zero_out <= eff_addr[7:0];
                  ext_bus.port_zero_oe  <= 1'b1;
                  // Register moves leave port two as it was, for paging
                  if (cpu_req.kind == KIND_EXT_PTR) begin
                     ext_bus.port_two_out <= eff_addr[15:8];
                  end
                  state_r   <= ST_ADDR;
                  cpu_ready <= 1'b0;
               end
            end
            ST_SFR: begin
               state_r   <= ST_IDLE;
               cpu_ready <= 1'b1;
            end
            ST_ADDR: begin
               // Address is latched outside on the falling address strobe
               ext_bus.ale  <= 1'b0;
               strobe_cnt_r <= 3'h0;
               if (ext_write_r) begin
                  ext_bus.port_zero_out <= ext_wdata_r;
                  ext_bus.wr_n          <= 1'b0;
               end else begin
                  ext_bus.port_zero_oe <= 1'b0;
                  ext_bus.rd_n  <= 1'b0;
               end
               state_r <= ST_STROBE;
            end
            ST_STROBE: begin
               strobe_cnt_r <= strobe_cnt_r + 3'h1;
               if (strobe_cnt_r == STROBE_LAST) begin
                  ext_bus.wr_n <= 1'b1;
                  ext_bus.rd_n <= 1'b1;
                  state_r      <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               ext_bus.port_zero_oe <= 1'b0;
               state_r              <= ST_IDLE;
               cpu_ready     <= 1'b1;
            end
            default: begin
               state_r   <= ST_IDLE;
               cpu_ready <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Response to the core
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_rsp <= '0;
      end else if (ce) begin
         cpu_rsp.done <= 1'b0;
         if (take && !(hit_sfr && !hit_local) && !hit_ext) begin
            cpu_rsp.done <= 1'b1;
            if (hit_local) begin
               cpu_rsp.rdata <= local_rdata;
            end else if (hit_exp_ram) begin
               cpu_rsp.rdata <= exp_ram_r[eff_addr[9:0]];
            end else begin
               cpu_rsp.rdata <= iram_r[cpu_req.addr[7:0]];
            end
         end else if (state_r == ST_SFR) begin
            cpu_rsp.done  <= 1'b1;
            cpu_rsp.rdata <= sfr_rdata;
         end else if (state_r == ST_STROBE && strobe_cnt_r == STROBE_LAST) begin
            // Synchroniser lag: data must be valid two cycles before strobe end
            if (!ext_write_r) begin
               cpu_rsp.rdata <= port_zero_sync_r;
            end
         end else if (state_r == ST_HOLD) begin
            cpu_rsp.done <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reset_clears: assert property (@(posedge clk)
      $past(rst) |-> (!ext_mem_select_r && !pointer_select_r))
      else $error("select bits not cleared by reset");

   a_exp_ram_pins: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && hit_exp_ram) |=> (cpu_rsp.done && !ext_bus.ale && ext_bus.rd_n && ext_bus.wr_n))
      else $error("expanded RAM access disturbed the bus");

   a_ri_internal: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && cpu_req.kind == KIND_EXT_REG && !ext_mem_select_r) |=> (state_r == ST_IDLE))
      else $error("register move left chip with select clear");

   a_high_ptr_ext: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && cpu_req.kind == KIND_EXT_PTR && data_pointer > EXP_RAM_TOP)
      |=> ext_bus.ale ##1 (!ext_bus.rd_n || !ext_bus.wr_n))
      else $error("high pointer move did not strobe");

   a_sel_all_ext: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && is_ext_move && ext_mem_select_r) |-> ##[1:3] (!ext_bus.rd_n || !ext_bus.wr_n))
      else $error("external move with select set did not strobe");

   a_ptr_high_port: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && hit_ext && cpu_req.kind == KIND_EXT_PTR)
      |=> (ext_bus.port_two_out == $past(data_pointer[15:8]) && ext_bus.port_zero_oe
           && ext_bus.port_zero_out == $past(data_pointer[7:0])))
      else $error("pointer address not on ports");

   a_strobe_len: assert property (@(posedge clk) disable iff (rst || !ce)
      $fell(ext_bus.rd_n)
      |-> (!ext_bus.rd_n && ext_bus.wr_n && !ext_bus.port_zero_oe) [*4] ##1 ext_bus.rd_n)
      else $error("read strobe wrong length");

   a_direct_sfr: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && hit_sfr && !hit_local) |=> (sfr_req.valid && sfr_req.addr == $past(cpu_req.addr[7:0])))
      else $error("direct upper access not sent to SPECIAL_FUNCTION_REGISTER");

   a_indirect_ram: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && cpu_req.kind == KIND_INDIRECT) |=> (cpu_rsp.done && !sfr_req.valid))
      else $error("indirect access reached SPECIAL_FUNCTION_REGISTER space");

   a_inc_toggle: assert property (@(posedge clk) disable iff (rst || !ce)
      (take && cpu_req.inc && is_direct && cpu_req.addr[7:0] == ADDR_AUX_ONE)
      |=> (pointer_select_r != $past(pointer_select_r)))
      else $error("increment did not toggle pointer select");

endmodule : dmd_decoder

`default_nettype wire

// >>> verif/dmd_ext_mem.sv
// External data memory model on the multiplexed port zero and port two bus
`timescale 1ns/1ps
`default_nettype none

module dmd_ext_mem
   import dmd_pkg::*;
(
   input  wire logic         clk,
   input  wire dmd_ext_bus_t ext_bus,
   output var  logic [7:0]   port_zero_in,
   output var  logic [15:0]  lat_addr,
   output var  int           n_ale,
   output var  int           n_rd,
   output var  int           n_wr
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_r;
   logic       rd_prev_r;
   logic       wr_prev_r;

   initial begin
      lat_addr = 16'h0000;
      last_r = 8'h00;
      rd_prev_r = 1'b1;
      wr_prev_r = 1'b1;
      n_ale = 0;
      n_rd = 0;
      n_wr = 0;
   end

   // ----------------------------------------------------------------
   // Address latch and strobe response
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (ext_bus.ale) begin
         lat_addr <= {ext_bus.port_two_out, ext_bus.port_zero_out};
         n_ale <= n_ale + 1;
      end
      if (!ext_bus.wr_n) begin
         mem[lat_addr] <= port_zero_in;
      end
      if (!ext_bus.wr_n && wr_prev_r) begin
         n_wr <= n_wr + 1;
      end
      if (!ext_bus.rd_n && rd_prev_r) begin
         n_rd <= n_rd + 1;
      end
      wr_prev_r <= ext_bus.wr_n;
      rd_prev_r <= ext_bus.rd_n;
      last_r <= port_zero_in;
   end

   // Released bus shows the inverse of its last level, never a stale value
   always_comb begin
      if (ext_bus.port_zero_oe) begin
         port_zero_in = ext_bus.port_zero_out;
      end else if (!ext_bus.rd_n) begin
         port_zero_in = mem[lat_addr];
      end else begin
         port_zero_in = ~last_r;
      end
   end
endmodule : dmd_ext_mem

`default_nettype wire

// >>> verif/data_memory_map_decoder_tb_top.sv
// Self-checking bench for the data memory map decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module data_memory_map_decoder_tb_top
   import dmd_pkg::*;
;
   logic         clk;
   logic         rst;
   logic         ce;
   dmd_cpu_req_t cpu_req;
   logic         cpu_ready;
   dmd_cpu_rsp_t cpu_rsp;
   dmd_sfr_req_t sfr_req;
   logic [7:0]   sfr_rdata;
   dmd_ext_bus_t ext_bus;
   logic [7:0]   port_zero_in;
   logic [15:0]  lat_addr;
   int           n_ale, n_rd, n_wr, c_ale, c_rd, c_wr;
   int           n_errors, check_count, seed;
   logic [7:0]   q, d, d2, sfr_a;
   logic [15:0]  a, a2;
   logic         sfr_seen;

   dmd_decoder dut_u (.clk(clk), .rst(rst), .ce(ce), .cpu_req(cpu_req),
      .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .ext_bus(ext_bus), .port_zero_in(port_zero_in));

   dmd_ext_mem mem_u (.clk(clk), .ext_bus(ext_bus), .port_zero_in(port_zero_in),
      .lat_addr(lat_addr), .n_ale(n_ale), .n_rd(n_rd), .n_wr(n_wr));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Request held from one edge until the take edge, then dropped
   task automatic acc(input logic [2:0] k, input logic w, input logic i,
                      input logic [15:0] ad, input logic [7:0] wd);
      int n;
      n = 0;
      cpu_req = '{valid:1'b1, write:w, inc:i, kind:k, addr:ad, wdata:wd};
      while (cpu_ready !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      cpu_req.valid = 1'b0;
      // Forward pulse stands only until the next edge, so look now
      sfr_seen = (sfr_req.valid === 1'b1);
      sfr_a = sfr_req.addr;
      while (cpu_rsp.done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
         if (sfr_req.valid === 1'b1) begin
            sfr_seen = 1'b1;
            sfr_a = sfr_req.addr;
         end
      end
      if (n >= 40) begin
         n_errors++;
         $display("CHECK FAILED t=%0t no answer", $time);
         wrap_up();
      end
      q = cpu_rsp.rdata;
   endtask : acc

   task automatic setptr(input logic [15:0] v);
      acc(KIND_DIRECT, 1'b1, 1'b0, {8'h00, ADDR_PTR_LOW}, v[7:0]);
      acc(KIND_DIRECT, 1'b1, 1'b0, {8'h00, ADDR_PTR_HIGH}, v[15:8]);
   endtask : setptr

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 28607;
      n_errors = 0;
      check_count = 0;
      rst = 1'b1;
      ce = 1'b1;
      cpu_req = '0;
      sfr_rdata = 8'h00;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      `CHK(cpu_ready, 1'b1)
      `CHK(ext_bus.rd_n & ext_bus.wr_n, 1'b1)
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_AUX}, 8'h00);
      `CHK(q[EXT_SEL_BIT], 1'b0)
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_AUX_ONE}, 8'h00);
      `CHK(q[PTR_SEL_BIT], 1'b0)
      $display("test reset done");

      d = 8'($random(seed));
      d2 = ~d;
      acc(KIND_DIRECT, 1'b1, 1'b0, 16'h007f, d);
      acc(KIND_INDIRECT, 1'b0, 1'b0, 16'h007f, 8'h00);
      `CHK(q, d)
      acc(KIND_INDIRECT, 1'b1, 1'b0, 16'h0090, d2);
      `CHK(sfr_seen, 1'b0)
      sfr_rdata = 8'($random(seed));
      acc(KIND_DIRECT, 1'b1, 1'b0, 16'h0090, d);
      `CHK(sfr_seen, 1'b1)
      `CHK(sfr_a, 8'h90)
      acc(KIND_INDIRECT, 1'b0, 1'b0, 16'h0090, 8'h00);
      `CHK(q, d2)
      acc(KIND_DIRECT, 1'b0, 1'b0, 16'h0090, 8'h00);
      `CHK(q, sfr_rdata)
      acc(KIND_STACK, 1'b1, 1'b0, 16'h00ff, d2);
      acc(KIND_INDIRECT, 1'b0, 1'b0, 16'h00ff, 8'h00);
      `CHK(q, d2)
      acc(KIND_STACK, 1'b0, 1'b0, 16'h007f, 8'h00);
      `CHK(q, d)
      $display("test internal done");

      c_ale = n_ale;
      c_rd = n_rd;
      c_wr = n_wr;
      setptr(16'h02ff);
      d = 8'($random(seed));
      acc(KIND_EXT_PTR, 1'b1, 1'b0, 16'h0000, d);
      acc(KIND_EXT_PTR, 1'b0, 1'b0, 16'h0000, 8'h00);
      `CHK(q, d)
      d2 = 8'($random(seed));
      acc(KIND_EXT_REG, 1'b1, 1'b0, 16'h0155, d2);
      setptr(16'h0055);
      acc(KIND_EXT_PTR, 1'b0, 1'b0, 16'h0000, 8'h00);
      `CHK(q, d2)
      `CHK(n_ale, c_ale)
      `CHK(n_rd + n_wr, c_rd + c_wr)
      $display("test expanded done");

      setptr(16'h0300);
      acc(KIND_EXT_PTR, 1'b1, 1'b0, 16'h0000, d);
      `CHK(lat_addr, 16'h0300)
      `CHK(n_wr, c_wr + 1)
      acc(KIND_EXT_PTR, 1'b0, 1'b0, 16'h0000, 8'h00);
      `CHK(q, d)
      `CHK(n_rd, c_rd + 1)
      for (int j = 0; j < 4; j++) begin
         a = 16'h0300 + 16'($unsigned($random(seed)) % 32'hfd00);
         d = 8'($random(seed));
         setptr(a);
         acc(KIND_EXT_PTR, 1'b1, 1'b0, 16'h0000, d);
         `CHK(lat_addr, a)
         acc(KIND_EXT_PTR, 1'b0, 1'b0, 16'h0000, 8'h00);
         `CHK(q, d)
      end
      $display("test external done");

      acc(KIND_DIRECT, 1'b1, 1'b0, {8'h00, ADDR_AUX}, 8'(1 << EXT_SEL_BIT));
      c_wr = n_wr;
      setptr(16'h0010);
      acc(KIND_EXT_PTR, 1'b1, 1'b0, 16'h0000, d);
      `CHK(n_wr, c_wr + 1)
      acc(KIND_EXT_PTR, 1'b0, 1'b0, 16'h0000, 8'h00);
      `CHK(q, d)
      acc(KIND_EXT_REG, 1'b1, 1'b0, 16'h0020, d2);
      `CHK(lat_addr, 16'h0020)
      `CHK(n_wr, c_wr + 2)
      acc(KIND_EXT_REG, 1'b0, 1'b0, 16'h0020, 8'h00);
      `CHK(q, d2)
      acc(KIND_DIRECT, 1'b1, 1'b0, {8'h00, ADDR_AUX}, 8'h00);
      $display("test select done");

      a = 16'($random(seed));
      a2 = ~a;
      setptr(a);
      acc(KIND_DIRECT, 1'b0, 1'b1, {8'h00, ADDR_AUX_ONE}, 8'h00);
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_AUX_ONE}, 8'h00);
      `CHK(q[PTR_SEL_BIT], 1'b1)
      setptr(a2);
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_PTR_LOW}, 8'h00);
      `CHK(q, a2[7:0])
      acc(KIND_DIRECT, 1'b0, 1'b1, {8'h00, ADDR_AUX_ONE}, 8'h00);
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_PTR_LOW}, 8'h00);
      `CHK(q, a[7:0])
      acc(KIND_DIRECT, 1'b0, 1'b0, {8'h00, ADDR_PTR_HIGH}, 8'h00);
      `CHK(q, a[15:8])
      $display("test pointers done");

      // Enable low must freeze everything, a pending write included
      acc(KIND_DIRECT, 1'b1, 1'b0, 16'h0011, d);
      ce = 1'b0;
      cpu_req = '{valid:1'b1, write:1'b1, inc:1'b0, kind:KIND_DIRECT, addr:16'h0011, wdata:~d};
      repeat (3) @(posedge clk);
      #1;
      cpu_req.valid = 1'b0;
      ce = 1'b1;
      @(posedge clk);
      #1;
      acc(KIND_DIRECT, 1'b0, 1'b0, 16'h0011, 8'h00);
      `CHK(q, d)
      $display("test enable done");
      wrap_up();
   end
endmodule : data_memory_map_decoder_tb_top

`default_nettype wire
